// >>> logic/pssc_pkg.sv
// Types shared by the supply configuration block.
package pssc_pkg;
    // Sequencer state codes.
    typedef enum logic [2:0] {
        PSSC_RESET = 3'h0,
        PSSC_ASLEEP = 3'h1,
        PSSC_WAKE1 = 3'h2,
        PSSC_WAKE2 = 3'h3,
        PSSC_AWAKE_WAIT = 3'h4,
        PSSC_AWAKE = 3'h5,
        PSSC_SLEEP1 = 3'h6,
        PSSC_SLEEP2 = 3'h7
    } pssc_state_t;
    // Supply controls that go to the converters and the tile clock gate.
    typedef struct packed {
        logic tile_clk_off;
        logic analog_pfm;
        logic core_pfm;
        logic io_en;
        logic pll_en;
        logic analog_en;
        logic core_en;
    } pssc_supply_t;
endpackage : pssc_pkg

// >>> logic/pssc_regs.svh
// Register offsets, field positions, the write mask and reset values of the supply configuration block.
`ifndef PSSC_REGS_SVH
`define PSSC_REGS_SVH
`define PSSC_OFF_AWAKE 12'h018
`define PSSC_OFF_SLEEP1 12'h01C
`define PSSC_OFF_SLEEP2 12'h020
`define PSSC_OFF_STATUS 12'h024
`define PSSC_OFF_CTRL 12'h028
`define PSSC_BIT_CORE_EN 0
`define PSSC_BIT_ANA_EN 1
`define PSSC_BIT_PLL_EN 4
`define PSSC_BIT_IO_EN 5
`define PSSC_BIT_CORE_PFM 8
`define PSSC_BIT_ANA_PFM 9
`define PSSC_BIT_TILE_OFF 14
`define PSSC_DWELL_LSB 16
`define PSSC_DWELL_MSB 20
`define PSSC_STATE_LSB 16
`define PSSC_STATE_MSB 18
`define PSSC_CFG_MASK 32'h001F_4333
`define PSSC_RST_AWAKE 32'h0000_0033
`define PSSC_RST_SLEEP1 32'h0010_0022
`define PSSC_RST_SLEEP2 32'h0010_0002
`define PSSC_RST_IDLE 32'h0000_0002
`endif

// >>> logic/pssc_top.sv
// Per-state supply configuration registers and the sleep sequencer that applies them.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "pssc_regs.svh"

module pssc_top (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Power-good reports from the supplies.
    input wire logic core_good,
    input wire logic analog_good,
    input wire logic pll_good,
    input wire logic io_good,
    // Supply controls.
    output pssc_pkg::pssc_supply_t supply
);

    // ****************************************************************
    // Functions
    // ****************************************************************

    // Unpacks a configuration word into supply controls.
    function automatic pssc_pkg::pssc_supply_t cfg_to_supply(input logic [31:0] w);
        pssc_pkg::pssc_supply_t s;
        s.tile_clk_off = w[`PSSC_BIT_TILE_OFF];
        s.analog_pfm = w[`PSSC_BIT_ANA_PFM];
        s.core_pfm = w[`PSSC_BIT_CORE_PFM];
        s.io_en = w[`PSSC_BIT_IO_EN];
        s.pll_en = w[`PSSC_BIT_PLL_EN];
        s.analog_en = w[`PSSC_BIT_ANA_EN];
        s.core_en = w[`PSSC_BIT_CORE_EN];
        return s;
    endfunction : cfg_to_supply

    // Masks a written word so reserved bits stay zero and bit 1 stays one.
    function automatic logic [31:0] cfg_clean(input logic [31:0] w);
        logic [31:0] r;
        r = w & `PSSC_CFG_MASK;
        r[`PSSC_BIT_ANA_EN] = 1'b1;
        return r;
    endfunction : cfg_clean

    // Picks the configuration word that a sequencer state applies to the supplies.
    function automatic logic [31:0] state_cfg(input pssc_pkg::pssc_state_t s, input logic [31:0] awake,
        input logic [31:0] sleep1, input logic [31:0] sleep2);
        logic [31:0] c;
        unique case (s)
            pssc_pkg::PSSC_AWAKE: c = awake;
            pssc_pkg::PSSC_AWAKE_WAIT: c = awake;
            pssc_pkg::PSSC_SLEEP1: c = sleep1;
            pssc_pkg::PSSC_SLEEP2: c = sleep2;
            default: c = `PSSC_RST_IDLE; // States outside this block keep only the analogue converter on.
        endcase
        return c;
    endfunction : state_cfg

    // ****************************************************************
    // Register file
    // ****************************************************************

    logic [31:0] awake_supply_config_q, awake_supply_config_d; // Awake configuration.
    logic [31:0] first_sleep_supply_config_q, first_sleep_supply_config_d; // First sleep configuration.
    logic [31:0] second_sleep_supply_config_q, second_sleep_supply_config_d; // Second sleep configuration.
    logic sleep_req_q, sleep_req_d; // Software request to go to sleep.
    logic wake_req_q, wake_req_d; // Software request to wake (pulse).
    logic wr_en; // Write takes effect this edge.

    assign wr_en = psel & penable & pwrite;
    assign pready = 1'b1; // Zero-wait slave.

    // Computes register next values from APB writes.
    always_comb begin
        awake_supply_config_d = awake_supply_config_q;
        first_sleep_supply_config_d = first_sleep_supply_config_q;
        second_sleep_supply_config_d = second_sleep_supply_config_q;
        sleep_req_d = sleep_req_q;
        wake_req_d = 1'b0;
        if (wr_en) begin
            unique case (paddr)
                `PSSC_OFF_AWAKE: begin
                    awake_supply_config_d = cfg_clean(pwdata) & ~32'h001F_0000;
                end
                `PSSC_OFF_SLEEP1: begin
                    first_sleep_supply_config_d = cfg_clean(pwdata);
                end
                `PSSC_OFF_SLEEP2: begin
                    second_sleep_supply_config_d = cfg_clean(pwdata);
                end
                `PSSC_OFF_CTRL: begin
                    sleep_req_d = pwdata[0];
                    wake_req_d = pwdata[1];
                end
                default: begin
                    // Unmapped and read-only offsets ignore writes.
                end
            endcase
        end
    end

    // Registers configuration state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            awake_supply_config_q <= `PSSC_RST_AWAKE;
            first_sleep_supply_config_q <= `PSSC_RST_SLEEP1;
            second_sleep_supply_config_q <= `PSSC_RST_SLEEP2;
            sleep_req_q <= 1'b0;
            wake_req_q <= 1'b0;
        end else begin
            awake_supply_config_q <= awake_supply_config_d;
            first_sleep_supply_config_q <= first_sleep_supply_config_d;
            second_sleep_supply_config_q <= second_sleep_supply_config_d;
            sleep_req_q <= sleep_req_d;
            wake_req_q <= wake_req_d;
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************

    pssc_pkg::pssc_state_t state_q, state_d; // Current sequencer state.
    logic [31:0] dwell_q, dwell_d; // Cycles spent in current state.
    logic [31:0] cur_cfg; // Configuration of current state.
    logic [31:0] dwell_len; // Required dwell in cycles.
    logic dwell_done; // Minimum dwell has expired.
    logic supplies_good; // Every enabled supply reports good.
    pssc_pkg::pssc_supply_t sup_d; // Next supply controls.

    // Selects the configuration of the active state.
    always_comb begin
        cur_cfg = state_cfg(state_q, awake_supply_config_q, first_sleep_supply_config_q,
            second_sleep_supply_config_q);
    end

    // Dwell of 2^N cycles; count reaches 2^N - 1 on the last cycle.
    assign dwell_len = 32'h0000_0001 << cur_cfg[`PSSC_DWELL_MSB:`PSSC_DWELL_LSB];
    assign dwell_done = (dwell_q == dwell_len - 32'h0000_0001);
    assign supplies_good = (~supply.core_en | core_good) & (~supply.analog_en | analog_good)
        & (~supply.pll_en | pll_good) & (~supply.io_en | io_good);

    // Computes next state and dwell count.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            pssc_pkg::PSSC_RESET: state_d = pssc_pkg::PSSC_AWAKE_WAIT;
            pssc_pkg::PSSC_AWAKE_WAIT: if (supplies_good) state_d = pssc_pkg::PSSC_AWAKE;
            pssc_pkg::PSSC_AWAKE: if (sleep_req_q) state_d = pssc_pkg::PSSC_SLEEP1;
            pssc_pkg::PSSC_SLEEP1: if (dwell_done && supplies_good) state_d = pssc_pkg::PSSC_SLEEP2;
            pssc_pkg::PSSC_SLEEP2: if (dwell_done && supplies_good) state_d = pssc_pkg::PSSC_ASLEEP;
            pssc_pkg::PSSC_ASLEEP: if (wake_req_q) state_d = pssc_pkg::PSSC_WAKE1;
            pssc_pkg::PSSC_WAKE1: state_d = pssc_pkg::PSSC_WAKE2;
            pssc_pkg::PSSC_WAKE2: state_d = pssc_pkg::PSSC_AWAKE_WAIT;
        endcase
        // Counter restarts at every state entry and saturates at the dwell end.
        if (state_d != state_q) begin
            dwell_d = 32'h0000_0000;
        end else if (!dwell_done) begin
            dwell_d = dwell_q + 32'h0000_0001;
        end else begin
            dwell_d = dwell_q;
        end
        // Supplies follow the state being entered, so they switch at the same edge as the state.
        sup_d = cfg_to_supply(state_cfg(state_d, awake_supply_config_q, first_sleep_supply_config_q,
            second_sleep_supply_config_q));
    end

    // Registers the sequencer, encoded on three bits.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= pssc_pkg::PSSC_RESET;
            dwell_q <= 32'h0000_0000;
            supply <= '0;
        end else begin
            state_q <= state_d;
            dwell_q <= dwell_d;
            supply <= sup_d;
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************

    logic [31:0] rdata_d; // Read mux output.

    // Selects the word for a read; unmapped offsets read zero with an error.
    always_comb begin
        rdata_d = 32'h0000_0000;
        pslverr = 1'b0;
        unique case (paddr)
            `PSSC_OFF_AWAKE: rdata_d = awake_supply_config_q;
            `PSSC_OFF_SLEEP1: rdata_d = first_sleep_supply_config_q;
            `PSSC_OFF_SLEEP2: rdata_d = second_sleep_supply_config_q;
            `PSSC_OFF_STATUS: begin
                rdata_d = {25'h000_0000, supply};
                rdata_d[`PSSC_STATE_MSB:`PSSC_STATE_LSB] = state_q;
            end
            `PSSC_OFF_CTRL: rdata_d = {31'h0000_0000, sleep_req_q};
            default: pslverr = psel & penable;
        endcase
    end

    assign prdata = rdata_d;

    // ****************************************************************
    // Checks
    // ****************************************************************

    // Entry into the first sleeping state with a dwell field of two, that is four cycles.
    sequence seq_sleep1_entry_n2;
        $rose(state_q == pssc_pkg::PSSC_SLEEP1) && first_sleep_supply_config_q[20:16] == 5'h02;
    endsequence
    // The first sleeping state stands for four cycles in a row.
    sequence seq_sleep1_hold4;
        (state_q == pssc_pkg::PSSC_SLEEP1) [*4];
    endsequence
    // Entry into the second sleeping state with a dwell field of one, that is two cycles.
    sequence seq_sleep2_entry_n1;
        $rose(state_q == pssc_pkg::PSSC_SLEEP2) && second_sleep_supply_config_q[20:16] == 5'h01;
    endsequence
    // The second sleeping state stands for two cycles in a row.
    sequence seq_sleep2_hold2;
        (state_q == pssc_pkg::PSSC_SLEEP2) [*2];
    endsequence

    // A settled awake state shows the awake register as it stood one cycle earlier.
    chk_awake_drive: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == pssc_pkg::PSSC_AWAKE && $past(state_q) == pssc_pkg::PSSC_AWAKE)
        |-> supply == cfg_to_supply($past(awake_supply_config_q)))
        else $error("Awake supplies differ from awake register.");
    // The first sleep setting reaches the supplies on the very cycle the state is entered.
    chk_sleep1_apply: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state_q == pssc_pkg::PSSC_SLEEP1) |-> supply == cfg_to_supply($past(first_sleep_supply_config_q)))
        else $error("First sleep supplies not applied on entry.");
    // The second sleep setting reaches the supplies on the very cycle the state is entered.
    chk_sleep2_apply: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state_q == pssc_pkg::PSSC_SLEEP2) |-> supply == cfg_to_supply($past(second_sleep_supply_config_q)))
        else $error("Second sleep supplies not applied on entry.");
    // A four-cycle dwell keeps the first sleeping state for all four cycles.
    chk_sleep1_dwell: assert property (@(posedge pclk) disable iff (!presetn)
        seq_sleep1_entry_n2 |-> seq_sleep1_hold4)
        else $error("First sleep left before its dwell.");
    // A two-cycle dwell keeps the second sleeping state for both cycles.
    chk_sleep2_dwell: assert property (@(posedge pclk) disable iff (!presetn)
        seq_sleep2_entry_n1 |-> seq_sleep2_hold2)
        else $error("Second sleep left before its dwell.");
    // The first sleeping state is left only when its counter has reached 2^N - 1.
    chk_dwell_bound: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q != $past(state_q) && state_q == pssc_pkg::PSSC_SLEEP2) |-> $past(dwell_q) == $past(dwell_len) - 1)
        else $error("Dwell length not 2^N.");
    chk_tile_gate: assert property (@(posedge pclk) disable iff (!presetn)
        ($stable(state_q) && state_q == pssc_pkg::PSSC_SLEEP1) |-> supply.tile_clk_off == $past(cur_cfg[14]))
        else $error("Tile clock gate wrong.");
    // In any settled state the IO supply enable follows bit 5 of that state's word.
    chk_io_enable: assert property (@(posedge pclk) disable iff (!presetn)
        ($stable(state_q) && state_q != pssc_pkg::PSSC_RESET) |-> supply.io_en == $past(cur_cfg[`PSSC_BIT_IO_EN]))
        else $error("IO supply enable wrong.");
    // In any settled state the core converter enable follows bit 0 of that state's word.
    chk_core_enable: assert property (@(posedge pclk) disable iff (!presetn)
        ($stable(state_q) && state_q != pssc_pkg::PSSC_RESET) |-> supply.core_en == $past(cur_cfg[`PSSC_BIT_CORE_EN]))
        else $error("Core converter enable wrong.");
    // The analogue converter enable can never be cleared by software.
    chk_ana_ro: assert property (@(posedge pclk) disable iff (!presetn)
        awake_supply_config_q[1] && first_sleep_supply_config_q[1] && second_sleep_supply_config_q[1])
        else $error("Analogue enable not one.");
    // Reserved bits of all three words stay zero, and the awake word has no dwell field.
    chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        ((awake_supply_config_q | first_sleep_supply_config_q | second_sleep_supply_config_q)
        & ~`PSSC_CFG_MASK) == 32'h0000_0000 && awake_supply_config_q[20:16] == 5'h00)
        else $error("Reserved bits set.");
    // A sleeping state is held while any supply it enables is not yet good.
    chk_advance_good: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q inside {pssc_pkg::PSSC_SLEEP1, pssc_pkg::PSSC_SLEEP2} && !supplies_good) |=> $stable(state_q))
        else $error("Advanced with a bad supply.");
    // A sleeping state is left at once when its dwell is over and its supplies are good.
    chk_dwell_advance: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q inside {pssc_pkg::PSSC_SLEEP1, pssc_pkg::PSSC_SLEEP2} && dwell_done && supplies_good)
        |=> state_q != $past(state_q))
        else $error("Sleeping state held past its dwell.");
    // Every state change starts the dwell count again from zero.
    chk_dwell_restart: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q != $past(state_q)) |-> dwell_q == 32'h0000_0000)
        else $error("Dwell counter not restarted.");

endmodule : pssc_top

// >>> tb/pssc_supply_model.sv
// Behavioural model of the supply converters, regulators and their power-good reports.
`timescale 1ns/100ps

module pssc_supply_model (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Controls from the block and the settle time chosen by the bench.
    input wire pssc_pkg::pssc_supply_t supply,
    input wire logic [3:0] settle,
    // Power-good reports.
    output logic core_good,
    output logic analog_good,
    output logic pll_good,
    output logic io_good
);
    // ********************************************************************
    // Settle timers
    // ********************************************************************
    logic [3:0] en; // Enables in the order io, pll, analog, core.
    logic [3:0][3:0] age_q; // Cycles each supply has been enabled, saturating.
    logic [3:0] good; // Power-good per supply.
    assign en = {supply.io_en, supply.pll_en, supply.analog_en, supply.core_en};
    // A timer restarts whenever its supply is switched off.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age_q <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                age_q[i] <= !en[i] ? 4'h0 : ((age_q[i] == 4'hF) ? age_q[i] : age_q[i] + 4'h1);
            end
        end
    end
    // A disabled supply reports low at once, so a stale good never lingers.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            good[i] = en[i] && (age_q[i] >= settle);
        end
    end
    assign {io_good, pll_good, analog_good, core_good} = good;
endmodule : pssc_supply_model

// >>> tb/tb.sv
// Self-checking testbench of the supply configuration block.
`timescale 1ns/100ps

module tb;
    // ********************************************************************
    // Signals and instances
    // ********************************************************************
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic pready, pslverr, core_good, analog_good, pll_good, io_good, err;
    logic [3:0] settle = 4'h0; // Power-good delay of the model.
    pssc_pkg::pssc_supply_t supply;
    int n_errors = 0, checks = 0, cnt1 = 0, cnt2 = 0;

    pssc_top u_pssc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .core_good(core_good), .analog_good(analog_good), .pll_good(pll_good), .io_good(io_good),
        .supply(supply));
    pssc_supply_model u_pssc_supply_model (.pclk(pclk), .presetn(presetn), .supply(supply), .settle(settle),
        .core_good(core_good), .analog_good(analog_good), .pll_good(pll_good), .io_good(io_good));

    // The clock toggles every 20 ns, half of its 40 ns period.
    always #20 pclk = ~pclk;
    // Cycles spent showing each sleep configuration.
    always @(posedge pclk) begin
        if (supply === 7'h62) cnt1++;
        if (supply === 7'h16) cnt2++;
    end

    // ********************************************************************
    // Tasks
    // ********************************************************************
    // Compares a seen value with the expected one and reports a mismatch.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One APB transfer; the access phase lasts until pready, and data and error are taken at that edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the watchdog ends a slave that never answers.
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Polls the status register until the sequencer reports the given state.
    task automatic wait_state(input logic [2:0] s);
        for (int i = 0; i < 200; i++) begin
            apb(1'b0, 12'h024, 32'h0000_0000);
            if (q[18:16] === s) break;
        end
        check({29'h0, q[18:16]}, {29'h0, s});
    endtask : wait_state
    // Prints the verdict and ends the run.
    task automatic summarize();
        if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    // ********************************************************************
    // Tests
    // ********************************************************************
    // The watchdog ends a hung run as a failure.
    initial begin
        #(40 * 20000);
        n_errors++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values of the three configuration words.
        apb(1'b0, 12'h018, 32'h0000_0000);
        check(q, 32'h0000_0033);
        apb(1'b0, 12'h01C, 32'h0000_0000);
        check(q, 32'h0010_0022);
        apb(1'b0, 12'h020, 32'h0000_0000);
        check(q, 32'h0010_0002);
        wait_state(3'h5);
        check({25'h0, supply}, 32'h0000_000F);
        // Reserved bits drop, bit 1 stays one and the awake word keeps no dwell field.
        apb(1'b1, 12'h018, 32'hFFFF_FFFF);
        apb(1'b0, 12'h018, 32'h0000_0000);
        check(q, 32'h0000_4333);
        apb(1'b1, 12'h020, 32'hFFFF_FFFF);
        apb(1'b0, 12'h020, 32'h0000_0000);
        check(q, 32'h001F_4333);
        apb(1'b1, 12'h018, 32'h0000_0000);
        apb(1'b0, 12'h018, 32'h0000_0000);
        check(q, 32'h0000_0002);
        check({31'h0000_0000, err}, 32'h0000_0000);
        // An unmapped offset answers with an error and zero data.
        apb(1'b0, 12'h040, 32'h0000_0000);
        check({err, q[30:0]}, 32'h8000_0000);
        // Awake: all on, both PFM. First sleep: tile gated, analogue PFM, N=2. Second sleep: core PFM, PLL, N=1.
        apb(1'b1, 12'h018, 32'h0000_0331);
        apb(1'b1, 12'h01C, 32'h0002_4202);
        apb(1'b1, 12'h020, 32'h0001_0112);
        // Two sleep and wake rounds: prompt supplies, then supplies that each need six cycles to settle.
        for (int r = 0; r < 2; r++) begin
            settle <= (r == 0) ? 4'h0 : 4'h6;
            cnt1 = 0;
            cnt2 = 0;
            apb(1'b1, 12'h028, 32'h0000_0001);
            wait_state(3'h1);
            check({25'h0, supply}, 32'h0000_0002);
            check(cnt1, 32'h0000_0004);
            // The second dwell is two cycles, or the settle time plus the enable cycle when the PLL is slow.
            if (r == 0) begin
                check(cnt2, 32'h0000_0002);
            end else begin
                check(cnt2, 32'h0000_0007);
            end
            apb(1'b1, 12'h028, 32'h0000_0002);
            wait_state(3'h5);
            check({25'h0, supply}, 32'h0000_003F);
        end
        summarize();
    end
endmodule : tb
